// *** hfp_defines.svh ***
`ifndef HFP_DEFINES_SVH
`define HFP_DEFINES_SVH

// Register byte offsets
`define HFP_HWCFG_OFF 12'h074
`define HFP_RXCTL_OFF 12'h078
`define HFP_RXINF_OFF 12'h07c
`define HFP_DROP_OFF 12'h0a0
`define HFP_ERR_OFF 12'h0a4

// hardware_config fields
`define HFP_HW_SOFTWARE_RESET_TRIGGER_BIT 0
`define HFP_HW_TO_BIT 1
`define HFP_HW_BW_BIT 2
`define HFP_HW_KB_LSB 16
`define HFP_HW_KB_MSB 19
`define HFP_HW_MBO_BIT 20
`define HFP_HW_KB_RST 4'h5

// rx_path_control and rx_fill_info fields
`define HFP_RX_SKIP_BIT 31
`define HFP_RXS_LSB 16
`define HFP_RXS_MSB 23
`define HFP_RXD_LSB 0
`define HFP_RXD_MSB 15

// Buffer geometry in bytes, interface buffer sizes in words
`define HFP_TOTAL_BYTES 17'h04000
`define HFP_TXSTAT_BYTES 17'h00200
`define HFP_RX_FULL_MARGIN 17'h00010
`define HFP_TX_MIL_WORDS 10'h200
`define HFP_RX_MIL_WORDS 6'h20

// Soft reset time-out: 10 us at 40 MHz
`define HFP_CLK_MHZ 40
`define HFP_RESET_TIMEOUT_FLAG_US 10
`define HFP_RESET_TIMEOUT_FLAG_CYC (`HFP_RESET_TIMEOUT_FLAG_US * `HFP_CLK_MHZ)

`endif

// *** hfp_pkg.sv ***
package hfp_pkg;

    typedef enum logic [0:0] {SR_IDLE, SR_WAIT} hfp_software_reset_trigger_t;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } hfp_apb_req_t;

    // APB answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } hfp_apb_rsp_t;

    // Whole block state
    typedef struct packed {
        logic [2:0] bw_sync;
        logic [2:0] rxc_sync;
        logic [2:0] txc_sync;
        logic bw;
        logic [3:0] tx_kb;
        logic mbo;
        logic software_reset_trigger_timeout;
        hfp_software_reset_trigger_t software_reset_trigger_st;
        logic [15:0] software_reset_trigger_cnt;
        logic rxc_seen;
        logic txc_seen;
        logic wr_unlock;
        logic tx_err;
        logic rx_err;
        logic skip_busy;
        logic [8:0] skip_left;
        logic [15:0] rx_data_used;
        logic [7:0] rx_status_used;
        logic [5:0] rx_mil_words;
        logic rx_dropping;
        logic [15:0] drop_cnt;
        logic [15:0] tx_data_used;
        logic [9:0] tx_mil_words;
        logic rx_full;
        logic tx_full;
        logic tx_valid;
        hfp_apb_rsp_t rsp;
    } hfp_state_t;

endpackage

// *** hfp_fifo_ctrl.sv ***
// Summary of operation
// - Bit 2 reads the bus width strap
// - Soft reset without PHY clocks times out
// - Soft reset clears registers, bit self-clears
// - Completed soft reset clears error flags
// - Writes ignored until first host read
// - Transmit allocation in KB, resets to five
// - Transmit status fixed 512 bytes, data rest
// - Receive allocation is 16384 minus transmit
// - Receive status takes one sixteenth
// - Receive data full four words early
// - Interface buffers fixed 2 KB, 128 bytes
// - Transmit buffer refills from data FIFO
// - Receive buffer overrun drops rest of the frame
// - Count each frame lost to overrun
// - Interface buffer levels hidden from host
// - Skip bit advances to next frame, self-clears
// - Status used words in bits 23:16
// - Data used bytes in bits 15:0
`include "hfp_defines.svh"

module hfp_fifo_ctrl (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from outside the clock domain
    input wire logic bus_width_strap,
    input wire logic phy_rx_clk,
    input wire logic phy_tx_clk,
    // MAC receive side, one word per valid
    input wire logic mac_rx_valid,
    input wire logic mac_rx_last,
    // MAC transmit side
    input wire logic mac_tx_pop,
    output logic mac_tx_valid,
    // Host data path, one word per strobe
    input wire logic rx_data_pop,
    input wire logic rx_status_pop,
    input wire logic [8:0] skip_frame_words,
    input wire logic tx_push,
    output logic rx_data_full,
    output logic tx_data_full,
    // Error events and flags
    input wire logic tx_error_evt,
    input wire logic rx_error_evt,
    output logic tx_error_flag,
    output logic rx_error_flag
);

    hfp_pkg::hfp_state_t st_q;
    hfp_pkg::hfp_state_t st_d;
    hfp_pkg::hfp_apb_req_t req;

    // Receive allocation in bytes from transmit KB
    function automatic logic [16:0] rx_total(input logic [3:0] kb);
        rx_total = `HFP_TOTAL_BYTES - {3'h0, kb, 10'h000};
    endfunction

    // Receive data FIFO size, status taking a sixteenth
    function automatic logic [16:0] rx_data_size(input logic [3:0] kb);
        logic [16:0] t;
        t = rx_total(kb);
        rx_data_size = t - {4'h0, t[16:4]};
    endfunction

    // Full threshold, four words short of the size
    function automatic logic [16:0] rx_full_thr(input logic [3:0] kb);
        rx_full_thr = rx_data_size(kb) - `HFP_RX_FULL_MARGIN;
    endfunction

    // Transmit data FIFO size after the fixed status part
    function automatic logic [16:0] tx_data_size(input logic [3:0] kb);
        tx_data_size = {3'h0, kb, 10'h000} - `HFP_TXSTAT_BYTES;
    endfunction

    // Reset image of the block state
    function automatic hfp_pkg::hfp_state_t reset_state();
        hfp_pkg::hfp_state_t r;
        r = '0;
        r.tx_kb = `HFP_HW_KB_RST;
        r.software_reset_trigger_st = hfp_pkg::SR_IDLE;
        return r;
    endfunction

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Next state
    always_comb begin
        logic wr_done;
        logic rd_done;
        logic rx_move;
        logic rx_pop_ok;
        logic rx_accept;
        logic tx_move;
        logic tx_in;
        logic [5:0] mil_after;
        logic [16:0] rx_thr;
        logic [16:0] rx_all;
        hfp_pkg::hfp_state_t keep;
        wr_done = 1'b0;
        rd_done = 1'b0;
        rx_move = 1'b0;
        rx_pop_ok = 1'b0;
        rx_accept = 1'b0;
        tx_move = 1'b0;
        tx_in = 1'b0;
        mil_after = '0;
        rx_thr = '0;
        rx_all = '0;
        keep = '0;
        st_d = st_q;

        // Three-stage synchronisers; strap taken when stages 2 and 3 agree, a PHY clock edge seen when they differ
        st_d.bw_sync = {st_q.bw_sync[1:0], bus_width_strap};
        st_d.rxc_sync = {st_q.rxc_sync[1:0], phy_rx_clk};
        st_d.txc_sync = {st_q.txc_sync[1:0], phy_tx_clk};
        if (st_q.bw_sync[1] == st_q.bw_sync[2]) begin
            st_d.bw = st_q.bw_sync[2];
        end

        // APB: ready one cycle after setup, transfer ends at ready edge
        wr_done = req.psel && req.penable && st_q.rsp.pready && req.pwrite;
        rd_done = req.psel && req.penable && st_q.rsp.pready && !req.pwrite;
        st_d.rsp.pready = 1'b0;
        if (req.psel && !req.penable) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.pslverr = 1'b0;
            st_d.rsp.prdata = '0;
            case (req.paddr)
                `HFP_HWCFG_OFF: begin
                    st_d.rsp.prdata[`HFP_HW_MBO_BIT] = st_q.mbo;
                    st_d.rsp.prdata[`HFP_HW_KB_MSB:`HFP_HW_KB_LSB] = st_q.tx_kb;
                    st_d.rsp.prdata[`HFP_HW_BW_BIT] = st_q.bw;
                    st_d.rsp.prdata[`HFP_HW_TO_BIT] = st_q.software_reset_trigger_timeout;
                    st_d.rsp.prdata[`HFP_HW_SOFTWARE_RESET_TRIGGER_BIT] = (st_q.software_reset_trigger_st == hfp_pkg::SR_WAIT);
                end
                `HFP_RXCTL_OFF: st_d.rsp.prdata[`HFP_RX_SKIP_BIT] = st_q.skip_busy;
                `HFP_RXINF_OFF: begin
                    // Interface buffer words are never included here
                    st_d.rsp.prdata[`HFP_RXS_MSB:`HFP_RXS_LSB] = st_q.rx_status_used;
                    st_d.rsp.prdata[`HFP_RXD_MSB:`HFP_RXD_LSB] = st_q.rx_data_used;
                end
                `HFP_DROP_OFF: st_d.rsp.prdata[15:0] = st_q.drop_cnt;
                `HFP_ERR_OFF: st_d.rsp.prdata[1:0] = {st_q.rx_err, st_q.tx_err};
                default: st_d.rsp.pslverr = 1'b1;
            endcase
        end

        // Any completed read unlocks writes
        if (rd_done) begin
            st_d.wr_unlock = 1'b1;
        end

        // Register writes, dropped while still locked
        if (wr_done && st_q.wr_unlock) begin
            case (req.paddr)
                `HFP_HWCFG_OFF: begin
                    st_d.mbo = req.pwdata[`HFP_HW_MBO_BIT];
                    st_d.tx_kb = req.pwdata[`HFP_HW_KB_MSB:`HFP_HW_KB_LSB];
                    if (req.pwdata[`HFP_HW_SOFTWARE_RESET_TRIGGER_BIT] && st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE) begin
                        st_d.software_reset_trigger_st = hfp_pkg::SR_WAIT;
                        st_d.software_reset_trigger_cnt = '0;
                        st_d.software_reset_trigger_timeout = 1'b0;
                        st_d.rxc_seen = 1'b0;
                        st_d.txc_seen = 1'b0;
                    end
                end
                `HFP_RXCTL_OFF: begin
                    if (req.pwdata[`HFP_RX_SKIP_BIT] && !st_q.skip_busy) begin
                        st_d.skip_busy = 1'b1;
                        st_d.skip_left = skip_frame_words;
                    end
                end
                default: ;
            endcase
        end

        // Error flags: sticky; a completed soft reset or nrst clears them, and the soft reset wins over a set
        if (tx_error_evt) begin
            st_d.tx_err = 1'b1;
        end
        if (rx_error_evt) begin
            st_d.rx_err = 1'b1;
        end

        // Receive: buffer drains into data FIFO unless it is full
        rx_move = (st_q.rx_mil_words != 6'h00) && !st_q.rx_full;
        rx_pop_ok = rx_data_pop && !st_q.skip_busy && (st_q.rx_data_used >= 16'h0004);
        if (st_q.skip_busy) begin
            // Skip discards one word per cycle up to the next frame
            if (st_q.skip_left == 9'h000 || st_q.rx_data_used < 16'h0004) begin
                st_d.skip_busy = 1'b0;
            end else begin
                st_d.skip_left = st_q.skip_left - 9'h001;
                rx_pop_ok = 1'b1;
            end
        end
        if (rx_move) begin
            st_d.rx_data_used = st_d.rx_data_used + 16'h0004;
        end
        if (rx_pop_ok) begin
            st_d.rx_data_used = st_d.rx_data_used - 16'h0004;
        end
        mil_after = st_q.rx_mil_words - {5'h00, rx_move};
        rx_accept = mac_rx_valid && !st_q.rx_dropping && (mil_after < `HFP_RX_MIL_WORDS);
        st_d.rx_mil_words = mil_after + {5'h00, rx_accept};
        if (mac_rx_valid && !rx_accept) begin
            // Overrun: rest of this frame up to its last word is lost
            st_d.rx_dropping = !mac_rx_last;
            if (mac_rx_last) begin
                st_d.drop_cnt = st_q.drop_cnt + 16'h0001;
            end
        end
        // Status capacity in words: a sixteenth of the receive bytes, four bytes a word
        rx_all = rx_total(st_q.tx_kb);
        if (rx_accept && mac_rx_last &&
            {9'h000, st_q.rx_status_used} < {6'h00, rx_all[16:6]}) begin
            st_d.rx_status_used = st_q.rx_status_used + 8'h01;
        end
        if (rx_status_pop && st_d.rx_status_used != 8'h00) begin
            st_d.rx_status_used = st_d.rx_status_used - 8'h01;
        end

        // Transmit: refill the interface buffer whenever it has room
        tx_move = (st_q.tx_data_used >= 16'h0004) && (st_q.tx_mil_words < `HFP_TX_MIL_WORDS);
        tx_in = tx_push && !st_q.tx_full;
        st_d.tx_data_used = st_q.tx_data_used + (tx_in ? 16'h0004 : 16'h0000) - (tx_move ? 16'h0004 : 16'h0000);
        st_d.tx_mil_words = st_q.tx_mil_words + {9'h000, tx_move}
                            - {9'h000, mac_tx_pop && st_q.tx_mil_words != 10'h000};

        // Soft reset waits for both PHY clocks to move
        if (st_q.software_reset_trigger_st == hfp_pkg::SR_WAIT) begin
            if (st_q.rxc_sync[1] != st_q.rxc_sync[2]) begin
                st_d.rxc_seen = 1'b1;
            end
            if (st_q.txc_sync[1] != st_q.txc_sync[2]) begin
                st_d.txc_seen = 1'b1;
            end
            st_d.software_reset_trigger_cnt = st_q.software_reset_trigger_cnt + 16'h0001;
            if (st_q.rxc_seen && st_q.txc_seen) begin
                // Completed: everything back to reset, pins and bus phase kept
                keep = st_d;
                st_d = reset_state();
                st_d.bw_sync = keep.bw_sync;
                st_d.rxc_sync = keep.rxc_sync;
                st_d.txc_sync = keep.txc_sync;
                st_d.bw = keep.bw;
                st_d.rsp = keep.rsp;
            end else if (st_q.software_reset_trigger_cnt == 16'(`HFP_RESET_TIMEOUT_FLAG_CYC - 1)) begin
                st_d.software_reset_trigger_st = hfp_pkg::SR_IDLE;
                st_d.software_reset_trigger_timeout = 1'b1;
            end
        end

        // Registered status outputs from the next levels
        rx_thr = rx_full_thr(st_d.tx_kb);
        st_d.rx_full = {1'b0, st_d.rx_data_used} >= rx_thr;
        st_d.tx_full = ({1'b0, st_d.tx_data_used} + 17'h00004) > tx_data_size(st_d.tx_kb);
        // Registered so the MAC never sees a decode glitch
        st_d.tx_valid = st_d.tx_mil_words != 10'h000;
    end

    // Single state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= reset_state();
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign prdata = st_q.rsp.prdata;
    assign pready = st_q.rsp.pready;
    assign pslverr = st_q.rsp.pslverr;
    assign rx_data_full = st_q.rx_full;
    assign tx_data_full = st_q.tx_full;
    assign mac_tx_valid = st_q.tx_valid;
    assign tx_error_flag = st_q.tx_err;
    assign rx_error_flag = st_q.rx_err;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    apb_ready_a: assert property (ce && psel && !penable |=> pready)
        else $error("ready not raised after setup");

    strap_read_a: assert property (ce && psel && !penable && paddr == `HFP_HWCFG_OFF
        |=> prdata[2] == $past(st_q.bw))
        else $error("strap bit mismatch");

    software_reset_trigger_timeout_a: assert property ($rose(st_q.software_reset_trigger_timeout) |-> $past(st_q.software_reset_trigger_st) == hfp_pkg::SR_WAIT
        && !($past(st_q.rxc_seen) && $past(st_q.txc_seen)))
        else $error("timeout without pending reset");

    software_reset_trigger_clear_a: assert property (ce && st_q.software_reset_trigger_st == hfp_pkg::SR_WAIT
        && st_q.rxc_seen && st_q.txc_seen
        |=> !tx_error_flag && !rx_error_flag && st_q.tx_kb == 4'h5 && !st_q.wr_unlock
        && st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE)
        else $error("soft reset left state");

    write_lock_a: assert property (ce && psel && penable && pready && pwrite && !st_q.wr_unlock
        && st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE |=> $stable(st_q.tx_kb) && $stable(st_q.skip_busy))
        else $error("locked write took effect");

    rx_full_a: assert property (rx_data_full == ({1'b0, st_q.rx_data_used} >= rx_full_thr(st_q.tx_kb)))
        else $error("full flag wrong");

    drop_count_a: assert property (ce && mac_rx_valid && mac_rx_last && st_q.rx_dropping
        && st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE |=> st_q.drop_cnt == $past(st_q.drop_cnt) + 16'h0001)
        else $error("drop not counted");

    skip_end_a: assert property (ce && st_q.skip_busy && st_q.skip_left == 9'h000
        && st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE |=> !st_q.skip_busy)
        else $error("skip did not finish");

    tx_mil_cap_a: assert property (st_q.tx_mil_words <= `HFP_TX_MIL_WORDS
        && st_q.rx_mil_words <= `HFP_RX_MIL_WORDS)
        else $error("interface buffer over size");

    // A refused push must never grow the transmit level
    tx_full_hold_a: assert property (ce && tx_data_full && tx_push
        |=> st_q.tx_data_used <= $past(st_q.tx_data_used))
        else $error("push taken while full");

    // Dead PHY clocks end the pending reset at the count
    software_reset_trigger_expire_a: assert property (ce && st_q.software_reset_trigger_st == hfp_pkg::SR_WAIT && !st_q.rxc_seen
        && st_q.software_reset_trigger_cnt == 16'(`HFP_RESET_TIMEOUT_FLAG_CYC - 1)
        |=> st_q.software_reset_trigger_st == hfp_pkg::SR_IDLE && st_q.software_reset_trigger_timeout)
        else $error("pending reset did not time out");

endmodule

// *** hfp_host_model.sv ***
module hfp_host_model (
    // Clock
    input wire logic clk,
    // APB master side
    output hfp_pkg::hfp_apb_req_t req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // One transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
endmodule

// *** test_host_fifo_partition_control.sv ***
`include "hfp_defines.svh"

module test_host_fifo_partition_control;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int kb; int rxd;} hfp_row_t;
    // Allocation and resulting data FIFO bytes, legal settings only
    hfp_row_t rows [13] = '{'{2, 13440}, '{3, 12480}, '{4, 11520}, '{5, 10560}, '{6, 9600}, '{7, 8640},
        '{8, 7680}, '{9, 6720}, '{10, 5760}, '{11, 4800}, '{12, 3840}, '{13, 2880}, '{14, 1920}};
    logic clk, nrst, ce, strap, phy_run, phy_rx, phy_tx, rx_valid, rx_last, tx_pop, tx_push;
    logic rx_pop, st_pop, tx_evt, rx_evt, pready, pslverr, err, rx_full, tx_full, tx_valid, tx_flag, rx_flag;
    logic [8:0] skip_words;
    logic [31:0] prdata, rd, s;
    hfp_pkg::hfp_apb_req_t req;
    int failures, total_checks, n, u;

    hfp_host_model host (.clk(clk), .req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    hfp_fifo_ctrl DUT (.clk(clk), .nrst(nrst), .ce(ce), .psel(req.psel), .penable(req.penable),
        .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_width_strap(strap), .phy_rx_clk(phy_rx), .phy_tx_clk(phy_tx),
        .mac_rx_valid(rx_valid), .mac_rx_last(rx_last), .mac_tx_pop(tx_pop), .mac_tx_valid(tx_valid),
        .rx_data_pop(rx_pop), .rx_status_pop(st_pop), .skip_frame_words(skip_words), .tx_push(tx_push),
        .rx_data_full(rx_full), .tx_data_full(tx_full), .tx_error_evt(tx_evt), .rx_error_evt(rx_evt),
        .tx_error_flag(tx_flag), .rx_error_flag(rx_flag));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // PHY clocks only toggle once the PHY is awake
    always @(posedge clk) if (phy_run) begin
        phy_rx <= ~phy_rx;
        phy_tx <= ~phy_tx;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic rdr(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, rd, err);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask

    // Pulse both error events; flags must stick
    task automatic set_errors;
        @(posedge clk);
        tx_evt <= 1'b1;
        rx_evt <= 1'b1;
        @(posedge clk);
        tx_evt <= 1'b0;
        rx_evt <= 1'b0;
        @(posedge clk);
        chk(32'({tx_flag, rx_flag}), 32'h3);
    endtask

    // MAC words, last flag every len words; valid left high between words
    task automatic mac_words(input int cnt, input int len, input bit stop_full);
        n = 0;
        while (n < cnt && !(stop_full && rx_full === 1'b1)) begin
            rx_valid <= 1'b1;
            rx_last <= (n % len == len - 1);
            @(posedge clk);
            n++;
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask

    // Completed soft reset; error flags clearing marks completion without a read
    task automatic soft_rst;
        set_errors();
        phy_run <= 1'b1;
        repeat (8) @(posedge clk);
        rdr(`HFP_HWCFG_OFF);
        wr(`HFP_HWCFG_OFF, 32'h0015_0001);
        u = 0;
        while (tx_flag !== 1'b0 && u < 1000) begin
            @(posedge clk);
            u++;
        end
        chk(32'({tx_flag, rx_flag}), 32'h0);
    endtask

    initial begin
        {nrst, strap, phy_run, phy_rx, phy_tx, rx_valid, rx_last, tx_pop, tx_push} = '0;
        {rx_pop, st_pop, tx_evt, rx_evt, skip_words, failures, total_checks} = '0;
        ce = 1'b1;
        strap = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // Write before any read must be dropped
        wr(`HFP_HWCFG_OFF, 32'h0018_0000);
        rdr(`HFP_HWCFG_OFF);
        chk(rd & 32'h000f_0007, 32'h0005_0004);
        rdr(`HFP_RXINF_OFF);
        chk(rd, 32'h0);
        rdr(12'h0fc);
        chk(32'(err), 32'h1);
        // One word through the transmit path
        @(posedge clk);
        tx_push <= 1'b1;
        @(posedge clk);
        tx_push <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(tx_valid), 32'h1);
        tx_pop <= 1'b1;
        @(posedge clk);
        tx_pop <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(tx_valid), 32'h0);
        // PHY asleep: reset must give up and keep errors
        set_errors();
        wr(`HFP_HWCFG_OFF, 32'h0015_0001);
        rdr(`HFP_HWCFG_OFF);
        chk(32'(rd[0]), 32'h1);
        repeat (420) @(posedge clk);
        rdr(`HFP_HWCFG_OFF);
        chk(32'(rd[1:0]), 32'h2);
        chk(32'({tx_flag, rx_flag}), 32'h3);
        foreach (rows[i]) begin
            strap <= i[0];
            soft_rst();
            wr(`HFP_HWCFG_OFF, {12'h001, 4'(rows[i].kb), 16'h0});
            rdr(`HFP_HWCFG_OFF);
            chk(rd & 32'h000f_0007, {12'h0, 4'h5, 13'h0, i[0], 2'b0});
            wr(`HFP_HWCFG_OFF, {12'h001, 4'(rows[i].kb), 16'h0});
            rdr(`HFP_HWCFG_OFF);
            chk(32'(rd[19:16]), rows[i].kb);
            // Fill until full; buffered words stay out of the count
            mac_words(4000, 256, 1'b1);
            u = n / 256;
            repeat (40) @(posedge clk);
            rdr(`HFP_RXINF_OFF);
            chk(32'(rd[15:0]), rows[i].rxd - 16);
            chk(32'(rd[23:16]), u);
            chk(32'(rx_full), 32'h1);
            s = rd;
            // With the data FIFO full, each 33-word frame overruns the 32-word buffer
            mac_words(99, 33, 1'b0);
            repeat (4) @(posedge clk);
            rdr(`HFP_DROP_OFF);
            chk(rd, 32'h3);
            rdr(`HFP_RXINF_OFF);
            chk(rd, s);
            // Skip the 256-word head frame
            skip_words <= 9'h100;
            wr(`HFP_RXCTL_OFF, 32'h8000_0000);
            rdr(`HFP_RXCTL_OFF);
            chk(32'(rd[31]), 32'h1);
            u = 0;
            do begin
                rdr(`HFP_RXCTL_OFF);
                u++;
            end while (rd[31] === 1'b1 && u < 200);
            chk(rd, 32'h0);
            rdr(`HFP_RXINF_OFF);
            u = int'(rd[15:0]);
            chk(32'(u >= rows[i].rxd - 1040 && u <= rows[i].rxd - 912), 32'h1);
            // One host pop of each FIFO once the skip is over
            rx_pop <= 1'b1;
            st_pop <= 1'b1;
            @(posedge clk);
            rx_pop <= 1'b0;
            st_pop <= 1'b0;
            rdr(`HFP_RXINF_OFF);
            chk(rd, {8'h00, s[23:16] - 8'h01, 16'(u - 4)});
            chk(32'(rx_full), 32'h0);
        end
        // Errors, allocation and write lock across a reset in mid-run
        set_errors();
        rdr(`HFP_ERR_OFF);
        chk(rd, 32'h3);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wr(`HFP_HWCFG_OFF, 32'h0018_0000);
        rdr(`HFP_ERR_OFF);
        chk(rd, 32'h0);
        rdr(`HFP_HWCFG_OFF);
        chk(32'(rd[19:16]), 32'h5);
        // Interface buffer fills first, then the data FIFO to its size
        u = 512 + (5 * 1024 - 512) / 4;
        n = 0;
        while (tx_full !== 1'b1 && n < 2000) begin
            tx_push <= 1'b1;
            @(posedge clk);
            n++;
        end
        tx_push <= 1'b0;
        chk(32'(n >= u && n <= u + 2), 32'h1);
        chk(32'(tx_valid), 32'h1);
        conclude();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #2_500_000;
        failures++;
        conclude();
    end
endmodule
